// *** dmc_pkg.sv ***
package dmc_pkg;
    localparam logic [7:0] DMC_CMD_RD_PROG = 8'h0b;
    localparam logic [7:0] DMC_CMD_WR_DATA = 8'h0c;
    localparam logic [7:0] DMC_CMD_RD_DATA = 8'h0d;
    localparam logic [7:0] DMC_CMD_PROG_CRC = 8'h0e;
    localparam logic [7:0] DMC_BLOCKED_BYTE = 8'hff;
    localparam logic [15:0] DMC_BLOCKED_CRC = 16'hffff;
    localparam logic [15:0] DMC_CRC_SEED = 16'hffff;
    localparam logic [15:0] DMC_CRC_POLY = 16'h1021;
    localparam int DMC_PROG_SIZE = 8192;

    typedef enum logic [8:0] {
        DMC_IDLE = 9'h001,
        DMC_ADDR_H = 9'h002,
        DMC_ADDR_L = 9'h004,
        DMC_SIZE_H = 9'h008,
        DMC_SIZE_L = 9'h010,
        DMC_XFER = 9'h020,
        DMC_CRC_RUN = 9'h040,
        DMC_CRC_HI = 9'h080,
        DMC_CRC_LO = 9'h100
    } dmc_state_e;
endpackage

// *** dmc_crc16.sv ***
`timescale 1ns/1ps
module dmc_crc16
    import dmc_pkg::*;
(
    // Control
    input wire logic ref_clk_i,
    input wire logic rst_i,
    input wire logic ce_i,
    input wire logic clear_i,
    input wire logic valid_i,
    input wire logic [7:0] data_i,
    // Result
    output logic [15:0] crc_o
);
    function automatic logic [15:0] crc_step(input logic [15:0] c,
                                             input logic [7:0] d);
        logic [15:0] r;
        r = c;
        for (int i = 7; i >= 0; i--)
        begin
            if (r[15] ^ d[i])
                r = {r[14:0], 1'b0} ^ DMC_CRC_POLY;
            else
                r = {r[14:0], 1'b0};
        end
        return r;
    endfunction

    always_ff @(posedge ref_clk_i)
    begin
        if (rst_i)
            crc_o <= DMC_CRC_SEED;
        else if (ce_i)
        begin
            if (clear_i)
                crc_o <= DMC_CRC_SEED;
            else if (valid_i)
                crc_o <= crc_step(crc_o, data_i);
        end
    end
endmodule

// *** dmc_debug_cmd.sv ***
`timescale 1ns/1ps
module dmc_debug_cmd
    import dmc_pkg::*;
#(
    parameter int PROG_SIZE = DMC_PROG_SIZE
)
(
    // Clock and reset
    input wire logic ref_clk_i,
    input wire logic rst_i,
    input wire logic ce_i,
    // Device state
    input wire logic halted_i,
    input wire logic read_protect_i,
    // Bytes from the debug serial line
    input wire logic rx_valid_i,
    input wire logic [7:0] rx_data_i,
    // Bytes to the debug serial line
    output logic tx_valid_o,
    output logic [7:0] tx_data_o,
    input wire logic tx_ready_i,
    // Program memory read port, data valid while strobe stands
    output logic prog_rd_o,
    output logic [15:0] prog_addr_o,
    input wire logic [7:0] prog_data_i,
    // Data memory port, read data valid while strobe stands
    output logic data_rd_o,
    output logic data_wr_o,
    output logic [15:0] data_addr_o,
    output logic [7:0] data_wdata_o,
    input wire logic [7:0] data_rdata_i,
    // Status
    output logic busy_o
);
    localparam logic [15:0] LAST_PROG = 16'(PROG_SIZE - 1);

    dmc_state_e state_reg;
    logic [7:0] cmd_reg;
    logic [15:0] addr_reg;
    logic [16:0] left_reg;
    logic rd_pend_reg;
    logic from_prog_reg;
    logic crc_pend_reg;
    logic crc_last_reg;
    logic [15:0] crc_val;
    logic rd_cmd;
    logic prog_ok;
    logic data_ok;

    assign rd_cmd = (cmd_reg == DMC_CMD_RD_PROG) ||
                    (cmd_reg == DMC_CMD_RD_DATA);
    assign prog_ok = halted_i && !read_protect_i;
    assign data_ok = halted_i;

    // ------------------------------------------------------------
    // Command sequencing
    // ------------------------------------------------------------
    always_ff @(posedge ref_clk_i)
    begin
        if (rst_i)
        begin
            state_reg <= DMC_IDLE;
            cmd_reg <= 8'h00;
            addr_reg <= 16'h0000;
            left_reg <= 17'h00000;
        end
        else if (ce_i)
        begin
            case (state_reg)
                DMC_IDLE:
                    if (rx_valid_i)
                    begin
                        cmd_reg <= rx_data_i;
                        if (rx_data_i == DMC_CMD_PROG_CRC)
                        begin
                            addr_reg <= 16'h0000;
                            state_reg <= DMC_CRC_RUN;
                        end
                        else if (rx_data_i == DMC_CMD_RD_PROG ||
                                 rx_data_i == DMC_CMD_WR_DATA ||
                                 rx_data_i == DMC_CMD_RD_DATA)
                            state_reg <= DMC_ADDR_H;
                    end
                DMC_ADDR_H:
                    if (rx_valid_i)
                    begin
                        addr_reg[15:8] <= rx_data_i;
                        state_reg <= DMC_ADDR_L;
                    end
                DMC_ADDR_L:
                    if (rx_valid_i)
                    begin
                        addr_reg[7:0] <= rx_data_i;
                        state_reg <= DMC_SIZE_H;
                    end
                DMC_SIZE_H:
                    if (rx_valid_i)
                    begin
                        left_reg <= {1'b0, rx_data_i, 8'h00};
                        state_reg <= DMC_SIZE_L;
                    end
                DMC_SIZE_L:
                    if (rx_valid_i)
                    begin
                        // Zero size means a full 64K transfer
                        if (left_reg[15:8] == 8'h00 && rx_data_i == 8'h00)
                            left_reg <= 17'h10000;
                        else
                            left_reg <= {left_reg[16:8], rx_data_i};
                        state_reg <= DMC_XFER;
                    end
                DMC_XFER:
                begin
                    if ((rd_cmd && tx_valid_o && tx_ready_i) ||
                        (!rd_cmd && rx_valid_i))
                    begin
                        addr_reg <= addr_reg + 16'h0001;
                        left_reg <= left_reg - 17'h00001;
                        if (left_reg == 17'h00001)
                            state_reg <= DMC_IDLE;
                    end
                end
                DMC_CRC_RUN:
                begin
                    // One byte per clock: delay tracks program size
                    if (addr_reg != LAST_PROG)
                        addr_reg <= addr_reg + 16'h0001;
                    if (crc_last_reg)
                        state_reg <= DMC_CRC_HI;
                end
                DMC_CRC_HI:
                    if (tx_valid_o && tx_ready_i)
                        state_reg <= DMC_CRC_LO;
                DMC_CRC_LO:
                    if (tx_valid_o && tx_ready_i)
                        state_reg <= DMC_IDLE;
                default:
                    state_reg <= DMC_IDLE;
            endcase
        end
    end

    // ------------------------------------------------------------
    // Memory strobes
    // ------------------------------------------------------------
    always_ff @(posedge ref_clk_i)
    begin
        if (rst_i)
        begin
            prog_rd_o <= 1'b0;
            prog_addr_o <= 16'h0000;
            data_rd_o <= 1'b0;
            data_wr_o <= 1'b0;
            data_addr_o <= 16'h0000;
            data_wdata_o <= 8'h00;
            rd_pend_reg <= 1'b0;
            from_prog_reg <= 1'b0;
            crc_pend_reg <= 1'b0;
            crc_last_reg <= 1'b0;
        end
        else if (ce_i)
        begin
            prog_rd_o <= 1'b0;
            data_rd_o <= 1'b0;
            data_wr_o <= 1'b0;
            crc_pend_reg <= 1'b0;
            rd_pend_reg <= 1'b0;
            if (state_reg == DMC_XFER && rd_cmd && !tx_valid_o &&
                !rd_pend_reg)
            begin
                rd_pend_reg <= 1'b1;
                from_prog_reg <= (cmd_reg == DMC_CMD_RD_PROG);
                prog_addr_o <= addr_reg;
                data_addr_o <= addr_reg;
                prog_rd_o <= (cmd_reg == DMC_CMD_RD_PROG) && prog_ok;
                data_rd_o <= (cmd_reg == DMC_CMD_RD_DATA) && data_ok;
            end
            if (state_reg == DMC_XFER && !rd_cmd && rx_valid_i)
            begin
                data_addr_o <= addr_reg;
                data_wdata_o <= rx_data_i;
                data_wr_o <= prog_ok;
            end
            crc_last_reg <= 1'b0;
            if (state_reg == DMC_CRC_RUN && !crc_last_reg)
            begin
                prog_addr_o <= addr_reg;
                prog_rd_o <= 1'b1;
                crc_pend_reg <= 1'b1;
                crc_last_reg <= (addr_reg == LAST_PROG);
            end
        end
    end

    // ------------------------------------------------------------
    // Reply bytes
    // ------------------------------------------------------------
    always_ff @(posedge ref_clk_i)
    begin
        if (rst_i)
        begin
            tx_valid_o <= 1'b0;
            tx_data_o <= 8'h00;
        end
        else if (ce_i)
        begin
            if (tx_valid_o && tx_ready_i)
                tx_valid_o <= 1'b0;
            if (rd_pend_reg)
            begin
                tx_valid_o <= 1'b1;
                if (from_prog_reg)
                    tx_data_o <= prog_ok ? prog_data_i
                                         : DMC_BLOCKED_BYTE;
                else
                    tx_data_o <= data_ok ? data_rdata_i
                                         : DMC_BLOCKED_BYTE;
            end
            // Load one cycle into CRC_HI so the last byte is folded in
            if (state_reg == DMC_CRC_HI && !tx_valid_o)
            begin
                tx_valid_o <= 1'b1;
                tx_data_o <= halted_i ? crc_val[15:8]
                                      : DMC_BLOCKED_CRC[15:8];
            end
            if (state_reg == DMC_CRC_HI && tx_valid_o && tx_ready_i)
            begin
                tx_valid_o <= 1'b1;
                tx_data_o <= halted_i ? crc_val[7:0]
                                      : DMC_BLOCKED_CRC[7:0];
            end
        end
    end

    always_ff @(posedge ref_clk_i)
    begin
        if (rst_i)
            busy_o <= 1'b0;
        else if (ce_i)
            busy_o <= (state_reg != DMC_IDLE);
    end

    dmc_crc16 u_crc
    (
        .ref_clk_i(ref_clk_i),
        .rst_i(rst_i),
        .ce_i(ce_i),
        .clear_i(state_reg == DMC_IDLE),
        .valid_i(crc_pend_reg),
        .data_i(prog_data_i),
        .crc_o(crc_val)
    );
endmodule

// *** dmc_mem_model.sv ***
`timescale 1ns/1ps
module dmc_mem_model (
    input wire logic ref_clk_i,
    input wire logic prog_rd_i,
    input wire logic [15:0] prog_addr_i,
    output logic [7:0] prog_data_o,
    input wire logic data_rd_i,
    input wire logic data_wr_i,
    input wire logic [15:0] data_addr_i,
    input wire logic [7:0] data_wdata_i,
    output logic [7:0] data_rdata_o
);
    // ----------------
    // Memories
    // ----------------
    logic [7:0] dmem [256];
    initial
    begin
        foreach (dmem[i]) dmem[i] = 8'(i) ^ 8'h3c;
    end
    // Data good only while the strobe stands, so late or stale reads show
    assign prog_data_o = prog_rd_i ? prog_addr_i[7:0] ^ 8'ha5
                                   : ~(prog_addr_i[7:0] ^ 8'ha5);
    assign data_rdata_o = data_rd_i ? dmem[data_addr_i[7:0]]
                                    : ~dmem[data_addr_i[7:0]];
    always @(posedge ref_clk_i)
    begin
        if (data_wr_i)
            dmem[data_addr_i[7:0]] <= data_wdata_i;
    end
endmodule

// *** dmc_debug_cmd_properties.sv ***
`timescale 1ns/1ps
module dmc_debug_cmd_properties #(
    parameter int PROG_SIZE = 8192
)
(
    // Clock and reset
    input wire logic ref_clk_i,
    input wire logic rst_i,
    input wire logic ce_i,
    // Device state
    input wire logic halted_i,
    input wire logic read_protect_i,
    // Debug serial line bytes
    input wire logic rx_valid_i,
    input wire logic [7:0] rx_data_i,
    input wire logic tx_valid_o,
    input wire logic [7:0] tx_data_o,
    input wire logic tx_ready_i,
    // Memory strobes
    input wire logic prog_rd_o,
    input wire logic [15:0] prog_addr_o,
    input wire logic data_rd_o,
    input wire logic data_wr_o,
    input wire logic [15:0] data_addr_o,
    input wire logic [7:0] data_wdata_o,
    // Status
    input wire logic busy_o
);
    // ----------------
    // Checks
    // ----------------
    default clocking cb @(posedge ref_clk_i); endclocking
    default disable iff (rst_i);
    logic seen_reg;
    logic [15:0] last_reg;
    // Cleared when idle so a new command may start anywhere
    always_ff @(posedge ref_clk_i)
        seen_reg <= (rst_i || !busy_o) ? 1'b0 : (seen_reg || prog_rd_o);
    always_ff @(posedge ref_clk_i)
        if (prog_rd_o)
            last_reg <= prog_addr_o;
    a_tx_hold: assert property (tx_valid_o && !tx_ready_i |=>
        tx_valid_o && $stable(tx_data_o)) else $error("reply dropped");
    a_rd_gate: assert property (data_rd_o |-> $past(halted_i))
        else $error("data read while running");
    a_wr_gate: assert property (data_wr_o |->
        $past(halted_i && !read_protect_i)) else $error("write not gated");
    a_wr_data: assert property (data_wr_o |-> $past(rx_valid_i && ce_i)
        && data_wdata_o == $past(rx_data_i)) else $error("bad write data");
    a_rd_pulse: assert property (data_rd_o && ce_i |=> !data_rd_o)
        else $error("read strobe too long");
    a_wr_step: assert property (data_wr_o && ce_i ##1 data_wr_o |->
        data_addr_o == 16'($past(data_addr_o) + 16'h1))
        else $error("write address not stepped");
    a_prog_step: assert property (prog_rd_o && seen_reg |->
        prog_addr_o == 16'(last_reg + 16'h1)) else $error("prog addr skip");
    a_tx_busy: assert property ($rose(tx_valid_o) |-> busy_o)
        else $error("reply outside command");
    a_reset_idle: assert property ($fell(rst_i) |->
        !tx_valid_o && !busy_o && !data_wr_o) else $error("not idle");
endmodule

bind dmc_debug_cmd dmc_debug_cmd_properties #(.PROG_SIZE(PROG_SIZE)) u_p (.*);

// *** tb.sv ***
`timescale 1ns/1ps
module tb
    import dmc_pkg::*;
;
    localparam int PSZ = 16;
    logic ref_clk_i = 0, rst_i = 1, ce_i = 1, halted_i = 1;
    logic read_protect_i = 0, rx_valid_i = 0, tx_ready_i = 0;
    logic [7:0] rx_data_i = 8'h00;
    logic tx_valid_o, prog_rd_o, data_rd_o, data_wr_o, busy_o;
    logic [7:0] tx_data_o, prog_data_i, data_wdata_o, data_rdata_i;
    logic [15:0] prog_addr_o, data_addr_o;
    int mismatches = 0, total_checks = 0;
    dmc_debug_cmd #(.PROG_SIZE(PSZ)) dut (.*);
    dmc_mem_model mem (.ref_clk_i, .prog_rd_i(prog_rd_o),
        .prog_addr_i(prog_addr_o), .prog_data_o(prog_data_i),
        .data_rd_i(data_rd_o), .data_wr_i(data_wr_o),
        .data_addr_i(data_addr_o), .data_wdata_i(data_wdata_o),
        .data_rdata_o(data_rdata_i));
    initial
    begin
        forever #2.5 ref_clk_i = ~ref_clk_i;
    end
    // ----------------
    // Host tasks
    // ----------------
    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        total_checks++;
        if (seen !== exp)
        begin
            mismatches++;
            $display("[ERR] %0t seen %h exp %h", $time, seen, exp);
        end
    endtask
    task automatic end_of_test();
        $display("checks %0d mismatches %0d", total_checks, mismatches);
        if (mismatches == 0 && total_checks > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask
    task automatic snd(input logic [7:0] b [$]);
        foreach (b[i])
        begin
            @(negedge ref_clk_i);
            rx_valid_i = 1'b1;
            rx_data_i = b[i];
        end
        @(negedge ref_clk_i);
        rx_valid_i = 1'b0;
    endtask
    // Stalls two cycles before taking each byte
    task automatic get(output logic [7:0] d, output int n);
        n = 0;
        while (tx_valid_o !== 1'b1)
        begin
            @(negedge ref_clk_i);
            n++;
            if (n > 100)
            begin
                mismatches++;
                end_of_test();
            end
        end
        repeat (2) @(negedge ref_clk_i);
        d = tx_data_o;
        tx_ready_i = 1'b1;
        @(negedge ref_clk_i);
        tx_ready_i = 1'b0;
    endtask
    // ----------------
    // Scenarios
    // ----------------
    task automatic t_prog();
        logic [7:0] d;
        int n;
        for (int m = 0; m < 3; m++)
        begin
            halted_i = m != 1;
            read_protect_i = m == 2;
            snd('{DMC_CMD_RD_PROG, 8'h00, 8'hfe, 8'h00, 8'h03});
            for (int i = 0; i < 3; i++)
            begin
                get(d, n);
                check(d, m == 0 ? 8'((8'hfe + 8'(i)) ^ 8'ha5) : 8'hff);
            end
        end
    endtask
    task automatic t_data();
        logic [7:0] d;
        logic [7:0] e [3] = '{8'h2c, 8'he3, 8'hf4};
        int n;
        snd('{DMC_CMD_WR_DATA, 8'h00, 8'h10, 8'h00, 8'h02, 8'hc1, 8'hd2});
        read_protect_i = 1'b0;
        snd('{DMC_CMD_WR_DATA, 8'h00, 8'h11, 8'h00, 8'h02, 8'he3, 8'hf4});
        read_protect_i = 1'b1;
        for (int h = 1; h >= 0; h--)
        begin
            halted_i = h[0];
            snd('{DMC_CMD_RD_DATA, 8'h00, 8'h10, 8'h00, 8'h03});
            for (int i = 0; i < 3; i++)
            begin
                get(d, n);
                check(d, h ? e[i] : 8'hff);
            end
        end
    endtask
    // Size zero is long; a reset cuts it short
    task automatic t_size0();
        logic [7:0] d;
        int n;
        halted_i = 1'b1;
        snd('{DMC_CMD_RD_DATA, 8'h00, 8'h00, 8'h00, 8'h00});
        for (int i = 0; i < 4; i++)
        begin
            get(d, n);
            check(d, 8'(i) ^ 8'h3c);
        end
        // A low clock enable must hold the transfer in place
        ce_i = 1'b0;
        repeat (4) @(negedge ref_clk_i);
        check(busy_o, 1'b1);
        ce_i = 1'b1;
        get(d, n);
        check(d, 8'h04 ^ 8'h3c);
        check(busy_o, 1'b1);
        rst_i = 1'b1;
        repeat (2) @(negedge ref_clk_i);
        rst_i = 1'b0;
        check(tx_valid_o, 1'b0);
    endtask
    task automatic t_crc();
        logic [7:0] hi, lo;
        logic [15:0] c = 16'hffff;
        int n, m;
        for (int a = 0; a < PSZ; a++)
        begin
            c ^= {8'(a) ^ 8'ha5, 8'h00};
            repeat (8) c = {c[14:0], 1'b0} ^ (c[15] ? 16'h1021 : 16'h0);
        end
        for (int h = 1; h >= 0; h--)
        begin
            halted_i = h[0];
            snd('{DMC_CMD_PROG_CRC});
            get(hi, n);
            get(lo, m);
            check({hi, lo}, h ? c : 16'hffff);
            check(16'(n >= PSZ), 16'h1);
        end
    endtask
    initial
    begin
        repeat (16) @(negedge ref_clk_i);
        rst_i = 1'b0;
        t_prog();
        t_data();
        t_size0();
        t_crc();
        end_of_test();
    end
endmodule
